// *** hw/vsp_pkg.sv ***
// Constants, types and register map of the viewport start and pan latch block
`default_nettype none

package vsp_pkg;
  localparam int START_W = 20;
  localparam int PAN_W = 2;
  localparam int HIGH_W = 4;
  localparam int IRQ_W = 4;
  localparam int BLANK_BIT = 7;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam int ADDR_TOP_LSB = 10;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_LCD_BLANK = 8'h3a;
  localparam logic [7:0] IDX_LCD_LOW = 8'h42;
  localparam logic [7:0] IDX_LCD_MID = 8'h43;
  localparam logic [7:0] IDX_LCD_HIGH = 8'h44;
  localparam logic [7:0] IDX_LCD_PAN = 8'h48;
  localparam logic [7:0] IDX_CRT_BLANK = 8'h58;
  localparam logic [7:0] IDX_CRT_LOW = 8'h62;
  localparam logic [7:0] IDX_CRT_MID = 8'h63;
  localparam logic [7:0] IDX_CRT_HIGH = 8'h64;
  localparam logic [7:0] IDX_CRT_PAN = 8'h68;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h70;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
  localparam int IRQ_LCD_VBL = 0;
  localparam int IRQ_CRT_VBL = 1;
  localparam int IRQ_LCD_FRM = 2;
  localparam int IRQ_CRT_FRM = 3;
  localparam logic [START_W-1:0] RST_START = 20'h00000;
  localparam logic [PAN_W-1:0] RST_PAN = 2'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
  localparam logic [31:0] RST_RDATA = 32'h00000000;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    AHB_IDLE = 2'b00,
    AHB_WR = 2'b01,
    AHB_RD_WAIT = 2'b10,
    AHB_RD_DONE = 2'b11
  } vsp_ahb_state_e;
endpackage

`default_nettype wire

// *** hw/vsp_pipe.sv ***
// One display pipe: programmed start address and pan, and their fetch-side latches
`default_nettype none

module vsp_pipe (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wr_low,
  input wire logic wr_mid,
  input wire logic wr_high,
  input wire logic wr_pan,
  input wire logic [7:0] wdata,
  input wire logic frame_start,
  input wire logic line_start,
  input wire logic vblank,
  output logic [vsp_pkg::START_W-1:0] start_addr,
  output logic [vsp_pkg::PAN_W-1:0] pan,
  output logic [vsp_pkg::START_W-1:0] fetch_start,
  output logic [vsp_pkg::PAN_W-1:0] fetch_pan,
  output logic vblank_rise,
  output logic frame_latched
);
  logic [vsp_pkg::START_W-1:0] start_ff, nxt_start, fstart_ff, nxt_fstart;
  logic [vsp_pkg::PAN_W-1:0] pan_ff, nxt_pan, fpan_ff, nxt_fpan;
  logic vbl_ff;

  always_comb begin
    nxt_start = start_ff;
    nxt_pan = pan_ff;
    if (wr_low) nxt_start[7:0] = wdata;
    if (wr_mid) nxt_start[15:8] = wdata;
    if (wr_high) nxt_start[19:16] = wdata[vsp_pkg::HIGH_W-1:0];
    // Pan is trusted to change only in blanking; mid-frame writes show as jitter
    if (wr_pan) nxt_pan = wdata[vsp_pkg::PAN_W-1:0];
    nxt_fstart = frame_start ? start_ff : fstart_ff;
    nxt_fpan = line_start ? pan_ff : fpan_ff;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      start_ff <= vsp_pkg::RST_START;
      pan_ff <= vsp_pkg::RST_PAN;
      fstart_ff <= vsp_pkg::RST_START;
      fpan_ff <= vsp_pkg::RST_PAN;
      vbl_ff <= 1'b0;
    end else begin
      start_ff <= nxt_start;
      pan_ff <= nxt_pan;
      fstart_ff <= nxt_fstart;
      fpan_ff <= nxt_fpan;
      vbl_ff <= vblank;
    end
  end

  assign start_addr = start_ff;
  assign pan = pan_ff;
  // Word offset handed to the fetch engine for the whole frame
  assign fetch_start = fstart_ff;
  assign fetch_pan = fpan_ff;
  assign vblank_rise = vblank & ~vbl_ff;
  assign frame_latched = frame_start;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_frame_latch_value: assert property (
    frame_start |=> fetch_start == $past(start_addr))
    else $error("start address not captured at frame start");
  a_frame_hold_between: assert property (!frame_start |=> $stable(fetch_start))
    else $error("fetch start changed outside frame start");
  a_line_latch_pan: assert property (line_start |=> fetch_pan == $past(pan))
    else $error("pan not captured at line start");
  a_pan_hold_line: assert property (!line_start |=> $stable(fetch_pan))
    else $error("fetch pan changed outside line start");
endmodule // vsp_pipe

`default_nettype wire

// *** hw/vsp_irq.sv ***
// Sticky event status, mask and level interrupt
`default_nettype none

module vsp_irq (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [vsp_pkg::IRQ_W-1:0] evt,
  input wire logic clr_wr,
  input wire logic mask_wr,
  input wire logic [vsp_pkg::IRQ_W-1:0] wdata,
  output logic [vsp_pkg::IRQ_W-1:0] status,
  output logic [vsp_pkg::IRQ_W-1:0] mask,
  output logic irq
);
  logic [vsp_pkg::IRQ_W-1:0] st_ff, nxt_st, mask_ff, nxt_mask;
  logic irq_ff, nxt_irq;

  always_comb begin
    // An event in the clearing cycle survives: set is applied after clear
    nxt_st = (clr_wr ? (st_ff & ~wdata) : st_ff) | evt;
    nxt_mask = mask_wr ? wdata : mask_ff;
    nxt_irq = |(nxt_st & nxt_mask);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= vsp_pkg::RST_IRQ;
      mask_ff <= vsp_pkg::RST_IRQ;
      irq_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
    end
  end

  assign status = st_ff;
  assign mask = mask_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_irq_level_match: assert property (irq == |(status & mask))
    else $error("interrupt level disagrees with status and mask");
  a_sticky_set_wins: assert property ((|evt) |=> (status & $past(evt)) == $past(evt))
    else $error("event lost in status register");
endmodule // vsp_irq

`default_nettype wire

// *** hw/vsp_top.sv ***
// AHB-Lite register slave and two display pipes for viewport start and pan
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`default_nettype none

module vsp_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic lcd_frame_start,
  input wire logic lcd_line_start,
  input wire logic lcd_vblank,
  input wire logic crt_frame_start,
  input wire logic crt_line_start,
  input wire logic crt_vblank,
  output logic [19:0] lcd_fetch_start_addr,
  output logic [1:0] lcd_fetch_pan,
  output logic [19:0] crt_fetch_start_addr,
  output logic [1:0] crt_fetch_pan,
  output logic irq
);
  //////////////////////////////////////////////////////////////////////////////
  // Bus slave state
  vsp_pkg::vsp_ahb_state_e state_ff, nxt_state;
  logic [7:0] idx_ff, nxt_idx;
  logic ok_ff, nxt_ok;
  logic [31:0] rdata_ff, nxt_rdata;
  logic accept;
  logic wr_fire;
  logic [31:0] rd_val;

  logic [1:0] frame_v, line_v, vbl_v, rise_v, frm_v;
  logic [1:0] wr_low_v, wr_mid_v, wr_high_v, wr_pan_v;
  logic [vsp_pkg::START_W-1:0] prog_start [2];
  logic [vsp_pkg::PAN_W-1:0] prog_pan [2];
  logic [vsp_pkg::START_W-1:0] fetch_start [2];
  logic [vsp_pkg::PAN_W-1:0] fetch_pan [2];
  logic [vsp_pkg::IRQ_W-1:0] irq_status, irq_mask, irq_evt;

  // Transfer size and burst type are not decoded; only single word transfers are used
  assign accept = hsel & hready & htrans[1];

  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_ok = ok_ff;
    nxt_rdata = rdata_ff;
    case (state_ff)
      vsp_pkg::AHB_RD_WAIT: begin
        // Extra cycle lets a write in the previous data phase land first
        nxt_rdata = rd_val;
        nxt_state = vsp_pkg::AHB_RD_DONE;
      end
      vsp_pkg::AHB_IDLE, vsp_pkg::AHB_WR, vsp_pkg::AHB_RD_DONE: begin
        if (accept) begin
          nxt_idx = haddr[vsp_pkg::IDX_MSB:vsp_pkg::IDX_LSB];
          nxt_ok = (haddr[31:vsp_pkg::ADDR_TOP_LSB] == 22'h000000) &&
                   (haddr[1:0] == 2'h0);
          nxt_state = hwrite ? vsp_pkg::AHB_WR : vsp_pkg::AHB_RD_WAIT;
        end else begin
          nxt_state = vsp_pkg::AHB_IDLE;
        end
      end
      default: begin
        nxt_state = vsp_pkg::AHB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= vsp_pkg::AHB_IDLE;
      idx_ff <= 8'h00;
      ok_ff <= 1'b0;
      rdata_ff <= vsp_pkg::RST_RDATA;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      ok_ff <= nxt_ok;
      rdata_ff <= nxt_rdata;
    end
  end

  assign hreadyout = (state_ff != vsp_pkg::AHB_RD_WAIT);
  assign hresp = vsp_pkg::HRESP_OKAY;
  assign hrdata = rdata_ff;
  // Writes commit at the end of the data phase; unmapped writes are dropped
  assign wr_fire = (state_ff == vsp_pkg::AHB_WR) & ok_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Read decode
  always_comb begin
    rd_val = 32'h00000000;
    if (ok_ff) begin
      case (idx_ff)
        vsp_pkg::IDX_LCD_BLANK: rd_val[vsp_pkg::BLANK_BIT] = lcd_vblank;
        vsp_pkg::IDX_CRT_BLANK: rd_val[vsp_pkg::BLANK_BIT] = crt_vblank;
        vsp_pkg::IDX_LCD_LOW: rd_val[7:0] = prog_start[0][7:0];
        vsp_pkg::IDX_LCD_MID: rd_val[7:0] = prog_start[0][15:8];
        vsp_pkg::IDX_LCD_HIGH: rd_val[3:0] = prog_start[0][19:16];
        vsp_pkg::IDX_LCD_PAN: rd_val[1:0] = prog_pan[0];
        vsp_pkg::IDX_CRT_LOW: rd_val[7:0] = prog_start[1][7:0];
        vsp_pkg::IDX_CRT_MID: rd_val[7:0] = prog_start[1][15:8];
        vsp_pkg::IDX_CRT_HIGH: rd_val[3:0] = prog_start[1][19:16];
        vsp_pkg::IDX_CRT_PAN: rd_val[1:0] = prog_pan[1];
        vsp_pkg::IDX_IRQ_STATUS: rd_val[vsp_pkg::IRQ_W-1:0] = irq_status;
        vsp_pkg::IDX_IRQ_MASK: rd_val[vsp_pkg::IRQ_W-1:0] = irq_mask;
        default: rd_val = 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Display pipes, index 0 is the LCD and 1 the CRT/TV
  assign frame_v = {crt_frame_start, lcd_frame_start};
  assign line_v = {crt_line_start, lcd_line_start};
  assign vbl_v = {crt_vblank, lcd_vblank};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pipe
      localparam logic [7:0] IL = (gi == 0) ? vsp_pkg::IDX_LCD_LOW : vsp_pkg::IDX_CRT_LOW;
      localparam logic [7:0] IM = (gi == 0) ? vsp_pkg::IDX_LCD_MID : vsp_pkg::IDX_CRT_MID;
      localparam logic [7:0] IH = (gi == 0) ? vsp_pkg::IDX_LCD_HIGH : vsp_pkg::IDX_CRT_HIGH;
      localparam logic [7:0] IP = (gi == 0) ? vsp_pkg::IDX_LCD_PAN : vsp_pkg::IDX_CRT_PAN;
      // Each strobe decodes its own index, so one pipe never sees the other's write
      assign wr_low_v[gi] = wr_fire & (idx_ff == IL);
      assign wr_mid_v[gi] = wr_fire & (idx_ff == IM);
      assign wr_high_v[gi] = wr_fire & (idx_ff == IH);
      assign wr_pan_v[gi] = wr_fire & (idx_ff == IP);

      vsp_pipe u_pipe (
        .mclk(mclk),
        .reset(reset),
        .wr_low(wr_low_v[gi]),
        .wr_mid(wr_mid_v[gi]),
        .wr_high(wr_high_v[gi]),
        .wr_pan(wr_pan_v[gi]),
        .wdata(hwdata[7:0]),
        .frame_start(frame_v[gi]),
        .line_start(line_v[gi]),
        .vblank(vbl_v[gi]),
        .start_addr(prog_start[gi]),
        .pan(prog_pan[gi]),
        .fetch_start(fetch_start[gi]),
        .fetch_pan(fetch_pan[gi]),
        .vblank_rise(rise_v[gi]),
        .frame_latched(frm_v[gi])
      );
    end
  endgenerate

  assign lcd_fetch_start_addr = fetch_start[0];
  assign lcd_fetch_pan = fetch_pan[0];
  assign crt_fetch_start_addr = fetch_start[1];
  assign crt_fetch_pan = fetch_pan[1];

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts: blanking start tells software its safe update window has opened
  always_comb begin
    irq_evt = vsp_pkg::RST_IRQ;
    irq_evt[vsp_pkg::IRQ_LCD_VBL] = rise_v[0];
    irq_evt[vsp_pkg::IRQ_CRT_VBL] = rise_v[1];
    irq_evt[vsp_pkg::IRQ_LCD_FRM] = frm_v[0];
    irq_evt[vsp_pkg::IRQ_CRT_FRM] = frm_v[1];
  end

  vsp_irq u_irq (
    .mclk(mclk),
    .reset(reset),
    .evt(irq_evt),
    .clr_wr(wr_fire & (idx_ff == vsp_pkg::IDX_IRQ_STATUS)),
    .mask_wr(wr_fire & (idx_ff == vsp_pkg::IDX_IRQ_MASK)),
    .wdata(hwdata[vsp_pkg::IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic lcd_touch;
  assign lcd_touch = wr_low_v[0] | wr_mid_v[0] | wr_high_v[0] | wr_pan_v[0];
  logic crt_touch;
  assign crt_touch = wr_low_v[1] | wr_mid_v[1] | wr_high_v[1] | wr_pan_v[1];

  sequence s_read_taken;
    accept & !hwrite;
  endsequence

  sequence s_read_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_wait_one: assert property (s_read_taken |=> s_read_answer)
    else $error("read answer not after exactly one wait state");
  a_lcd_blank_bit: assert property (
    (state_ff == vsp_pkg::AHB_RD_DONE) && ok_ff && (idx_ff == vsp_pkg::IDX_LCD_BLANK)
    |-> (hrdata[7] == $past(lcd_vblank)) && (hrdata[6:0] == 7'h00))
    else $error("lcd blanking status read wrong");
  a_crt_blank_bit: assert property (
    (state_ff == vsp_pkg::AHB_RD_DONE) && ok_ff && (idx_ff == vsp_pkg::IDX_CRT_BLANK)
    |-> (hrdata[7] == $past(crt_vblank)) && (hrdata[6:0] == 7'h00))
    else $error("crt blanking status read wrong");
  a_pipe_isolation: assert property (
    lcd_touch |=> $stable(prog_start[1]) && $stable(prog_pan[1]))
    else $error("lcd write disturbed crt pipe");
  a_pan_write_value: assert property (
    wr_pan_v[1] |=> prog_pan[1] == $past(hwdata[1:0]))
    else $error("crt pan write not stored");
  a_crt_isolation: assert property (
    crt_touch |=> $stable(prog_start[0]) && $stable(prog_pan[0]))
    else $error("crt write disturbed lcd pipe");

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the bus answer
  logic wr_taken;
  logic rd_landing;
  assign wr_taken = accept & hwrite;
  assign rd_landing = (state_ff == vsp_pkg::AHB_RD_DONE);

  sequence s_write_taken;
    wr_taken;
  endsequence

  sequence s_write_answer;
    hreadyout && (state_ff == vsp_pkg::AHB_WR);
  endsequence

  // A write never stalls, so software can stream the start bytes inside blanking
  a_write_no_wait: assert property (s_write_taken |=> s_write_answer)
    else $error("write data phase stalled");
  a_resp_okay: assert property (hresp == vsp_pkg::HRESP_OKAY)
    else $error("error response driven");
  // Read data stands until the next read replaces it
  a_rdata_hold: assert property ((state_ff != vsp_pkg::AHB_RD_WAIT) |=> $stable(hrdata))
    else $error("read data changed outside a read");
  a_unmapped_read_zero: assert property (rd_landing && !ok_ff |-> hrdata == 32'h00000000)
    else $error("unmapped read returned data");
  // Dropped writes must not reach either start address or the interrupt mask
  a_unmapped_write_drop: assert property (
    (state_ff == vsp_pkg::AHB_WR) && !ok_ff
    |=> $stable(prog_start[0]) && $stable(prog_start[1]) && $stable(irq_mask))
    else $error("unmapped write reached a register");

  //////////////////////////////////////////////////////////////////////////////
  // Stored bytes and fetch latches, once per pipe
  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_store_chk
      a_low_write_value: assert property (
        wr_low_v[gc] |=> prog_start[gc][7:0] == $past(hwdata[7:0]))
        else $error("low start byte write not stored");
      a_mid_write_value: assert property (
        wr_mid_v[gc] |=> prog_start[gc][15:8] == $past(hwdata[7:0]))
        else $error("mid start byte write not stored");
      a_high_write_value: assert property (
        wr_high_v[gc] |=> prog_start[gc][19:16] == $past(hwdata[vsp_pkg::HIGH_W-1:0]))
        else $error("high start byte write not stored");
      a_pan_write_stored: assert property (
        wr_pan_v[gc] |=> prog_pan[gc] == $past(hwdata[vsp_pkg::PAN_W-1:0]))
        else $error("pan write not stored");
      a_start_fetch_word: assert property (
        frame_v[gc] |=> fetch_start[gc] == $past(prog_start[gc]))
        else $error("fetch word offset differs from programmed start");
      a_pan_fetch_value: assert property (
        line_v[gc] |=> fetch_pan[gc] == $past(prog_pan[gc]))
        else $error("fetch pan differs from programmed pan");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Event flags and their clearing
  a_lcd_vbl_flag: assert property (
    rise_v[0] |=> irq_status[vsp_pkg::IRQ_LCD_VBL])
    else $error("lcd blanking start not flagged");
  a_crt_vbl_flag: assert property (
    rise_v[1] |=> irq_status[vsp_pkg::IRQ_CRT_VBL])
    else $error("crt blanking start not flagged");
  a_lcd_frm_flag: assert property (
    frm_v[0] |=> irq_status[vsp_pkg::IRQ_LCD_FRM])
    else $error("lcd frame start not flagged");
  a_crt_frm_flag: assert property (
    frm_v[1] |=> irq_status[vsp_pkg::IRQ_CRT_FRM])
    else $error("crt frame start not flagged");
  // Set wins, so only a quiet cycle proves the clear
  a_status_clear: assert property (
    wr_fire && (idx_ff == vsp_pkg::IDX_IRQ_STATUS) && (irq_evt == vsp_pkg::RST_IRQ)
    |=> (irq_status & $past(hwdata[vsp_pkg::IRQ_W-1:0])) == vsp_pkg::RST_IRQ)
    else $error("status bit not cleared by a one");
  a_mask_write_value: assert property (
    wr_fire && (idx_ff == vsp_pkg::IDX_IRQ_MASK)
    |=> irq_mask == $past(hwdata[vsp_pkg::IRQ_W-1:0]))
    else $error("interrupt mask write not stored");
endmodule // vsp_top

`default_nettype wire

// *** sim/vsp_disp_model.sv ***
// Display timing partner: frame, line and vertical blanking strobes for one pipe
`default_nettype none

module vsp_disp_model #(
  parameter int H = 8,
  parameter int V = 4,
  parameter int B = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic run,
  output logic frame_start,
  output logic line_start,
  output logic vblank
);
  timeunit 1ns;
  timeprecision 1ps;
  int hc;
  int vc;

  always @(posedge mclk) begin
    if (reset) begin
      hc <= 0;
      vc <= 0;
    end else if (run) begin
      if (hc == H - 1) begin
        hc <= 0;
        vc <= (vc == V + B - 1) ? 0 : vc + 1;
      end else begin
        hc <= hc + 1;
      end
    end
  end

  // Stopping freezes the raster so blanking holds a known level
  assign frame_start = run && !reset && hc == 0 && vc == 0;
  assign line_start = run && !reset && hc == 0 && vc < V;
  assign vblank = vc >= V;
endmodule // vsp_disp_model

`default_nettype wire

// *** sim/tb.sv ***
// Self-checking testbench for the viewport start and pan latch block
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
////////////////////////////////////////////////////////////////////////////////
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] hsize = 3'h0;
  logic [1:0] aoff = 2'h0;
  logic hreadyout, hresp, irq;
  logic [31:0] hrdata;
  logic [1:0] run = 2'b00;
  logic [1:0] fs, ls, vb;
  logic [19:0] lfa, cfa;
  logic [1:0] lfp, cfp;
  logic [19:0] prog_s [2] = '{20'h0, 20'h0};
  logic [1:0] prog_p [2] = '{2'h0, 2'h0};
  logic [19:0] exp_s [2];
  logic [1:0] exp_p [2];
  int n_fail = 0;
  int comparisons = 0;
  logic [7:0] idx_tab [2][5] = '{
    '{vsp_pkg::IDX_LCD_BLANK, vsp_pkg::IDX_LCD_LOW, vsp_pkg::IDX_LCD_MID,
      vsp_pkg::IDX_LCD_HIGH, vsp_pkg::IDX_LCD_PAN},
    '{vsp_pkg::IDX_CRT_BLANK, vsp_pkg::IDX_CRT_LOW, vsp_pkg::IDX_CRT_MID,
      vsp_pkg::IDX_CRT_HIGH, vsp_pkg::IDX_CRT_PAN}};

  // Unequal rasters so the two pipes never pulse in lock step
  vsp_disp_model lcd_disp (.mclk(mclk), .reset(reset),
    .run(run[0]), .frame_start(fs[0]), .line_start(ls[0]), .vblank(vb[0]));
  vsp_disp_model #(.H(10), .V(3), .B(4)) crt_disp (.mclk(mclk), .reset(reset),
    .run(run[1]), .frame_start(fs[1]), .line_start(ls[1]), .vblank(vb[1]));

  vsp_top DUT (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .lcd_frame_start(fs[0]), .lcd_line_start(ls[0]), .lcd_vblank(vb[0]),
    .crt_frame_start(fs[1]), .crt_line_start(ls[1]), .crt_vblank(vb[1]),
    .lcd_fetch_start_addr(lfa), .lcd_fetch_pan(lfp), .crt_fetch_start_addr(cfa),
    .crt_fetch_pan(cfp), .irq(irq));

  initial forever #25 mclk = ~mclk;
////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task wait_rdy;
    int n;
    n = 0;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40) begin n_fail++; end_sim(); end
  endtask

  task bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {22'h0, idx, aoff};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    `CHK(hresp, vsp_pkg::HRESP_OKAY)
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task rd_chk(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    `CHK(x, e)
  endtask

  // Reposition one pipe inside its blanking interval, then read back its four registers and the other pipe's low byte and pan
  task move(input int p);
    logic [31:0] r;
    logic [19:0] s;
    logic [1:0] pn;
    int n;
    s = 20'($urandom);
    pn = 2'($urandom);
    for (int lvl = 0; lvl < 2; lvl++) begin
      n = 0;
      do begin bus(1'b0, idx_tab[p][0], 32'h0, r); n++; end
        while (r[7] !== lvl[0] && n < 200);
      if (n >= 200) begin n_fail++; end_sim(); end
    end
    wr(idx_tab[p][1], {24'h0, s[7:0]});
    prog_s[p][7:0] <= s[7:0];
    wr(idx_tab[p][2], {24'h0, s[15:8]});
    prog_s[p][15:8] <= s[15:8];
    wr(idx_tab[p][3], {28'hfffffff, s[19:16]});
    prog_s[p][19:16] <= s[19:16];
    wr(idx_tab[p][4], {30'h3fffffff, pn});
    prog_p[p] <= pn;
    rd_chk(idx_tab[p][1], {24'h0, s[7:0]});
    rd_chk(idx_tab[p][2], {24'h0, s[15:8]});
    rd_chk(idx_tab[p][3], {28'h0, s[19:16]});
    rd_chk(idx_tab[p][4], {30'h0, pn});
    rd_chk(idx_tab[1-p][1], {24'h0, prog_s[1-p][7:0]});
    rd_chk(idx_tab[1-p][4], {30'h0, prog_p[1-p]});
  endtask
////////////////////////////////////////////////////////////////////////////////
  // Reference latches follow the strobes the design sees, at the same edges
  always @(posedge mclk) begin
    for (int p = 0; p < 2; p++) begin
      if (reset) begin
        exp_s[p] <= 20'h0;
        exp_p[p] <= 2'h0;
      end else begin
        if (fs[p]) exp_s[p] <= prog_s[p];
        if (ls[p]) exp_p[p] <= prog_p[p];
      end
    end
  end

  always @(negedge mclk) begin
    if (!reset) begin
      `CHK(lfa, exp_s[0])
      `CHK(cfa, exp_s[1])
      `CHK(lfp, exp_p[0])
      `CHK(cfp, exp_p[1])
    end
  end

  initial begin
    void'($urandom(11559));
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 2; i++) begin
      for (int j = 0; j < 5; j++) rd_chk(idx_tab[i][j], 32'h0);
    end
    rd_chk(vsp_pkg::IDX_IRQ_STATUS, 32'h0);
    run <= 2'b11;
    repeat (3) begin
      move(0);
      move(1);
    end
    repeat (200) @(posedge mclk);
    run <= 2'b00;
    @(posedge mclk);
    rd_chk(idx_tab[0][0], {24'h0, vb[0], 7'h0});
    rd_chk(idx_tab[1][0], {24'h0, vb[1], 7'h0});
    rd_chk(vsp_pkg::IDX_IRQ_STATUS, 32'hf);
    `CHK(irq, 1'b0)
    wr(vsp_pkg::IDX_IRQ_MASK, 32'h1);
    repeat (2) @(negedge mclk);
    `CHK(irq, 1'b1)
    @(posedge mclk);
    wr(vsp_pkg::IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(negedge mclk);
    `CHK(irq, 1'b0)
    @(posedge mclk);
    rd_chk(vsp_pkg::IDX_IRQ_STATUS, 32'he);
    rd_chk(vsp_pkg::IDX_IRQ_MASK, 32'h1);
    // Unmapped slot must swallow writes and read back zero
    wr(8'h7f, 32'hff);
    rd_chk(8'h7f, 32'h0);
    // Misaligned accesses are refused: the write is lost and the read gives zero
    aoff = 2'h1;
    wr(idx_tab[0][4], {30'h0, ~prog_p[0]});
    rd_chk(idx_tab[0][1], 32'h0);
    aoff = 2'h0;
    rd_chk(idx_tab[0][4], {30'h0, prog_p[0]});
    end_sim();
  end
endmodule // tb

`default_nettype wire
